/* File: design/ssms_top.sv */
// Purpose: Two-channel synchronous serial master/slave with APB registers
// Assumes: Pins and timer signals are synchronous to pclk
// Notes: Each timer clock level must last at least one pclk; each underflow pulse exactly one, as each high pclk counts
//
// Our own choices: the register offsets and the APB register port.
`default_nettype none

module ssms_top
  import ssms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] timer_clk,
  input wire logic [NUM_CH-1:0] timer_underflow,
  input wire ssms_pin_in_type [NUM_CH-1:0] pin_in,
  output ssms_pin_out_type [NUM_CH-1:0] pin_out,
  output ssms_flags_type [NUM_CH-1:0] cause
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[11:6] == 6'h00) && (a[1:0] == 2'h0) && (a[4:0] <= OFS_FLAG);
  endfunction

  function automatic logic hit(input logic [11:0] a, input int ch, input logic [4:0] ofs);
    hit = addr_ok(a) && (a[5] == ch[0]) && (a[4:0] == ofs);
  endfunction

  // Position of bit number n of a frame inside the data word
  function automatic logic [3:0] bit_pos(input logic lsb, input logic [3:0] len_m1, input logic [4:0] n);
    bit_pos = lsb ? n[3:0] : (len_m1 - n[3:0]);
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] ch_rdata [NUM_CH];
  logic setup, done, wr_done, rd_done;

  always_comb begin
    setup = psel && !penable && !pready_reg;
    done = psel && penable && pready_reg;
    wr_done = done && pwrite && !pslverr_reg;
    rd_done = done && !pwrite && !pslverr_reg;
    pready_next = setup;
    pslverr_next = setup && !addr_ok(paddr);
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = addr_ok(paddr) ? ch_rdata[paddr[5]] : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ssms_mode_type mode_reg, mode_next;
    ssms_state_type st_reg, st_next;
    logic en_reg, en_next, srst_reg, srst_next;
    logic [15:0] txd_reg, txd_next, rxd_reg, rxd_next;
    logic [15:0] txw_reg, txw_next, rxw_reg, rxw_next;
    logic tx_full_reg, tx_full_next, rbf_reg, rbf_next;
    logic tend_reg, tend_next, ovr_reg, ovr_next;
    logic [4:0] cnt_reg, cnt_next;
    logic phase_reg, phase_next, tog_reg, tog_next;
    logic raw_prev_reg, raw_prev_next, act_prev_reg, act_prev_next;
    logic sdo_reg, sdo_next;
    ssms_pin_out_type pin_reg, pin_next;
    ssms_flags_type cause_reg, cause_next;
    logic raw, act, sel, lead, trail, samp, last, load, wr_tx, rd_rx;
    logic [15:0] rx_word;

    assign ch_rdata[c] = hit(paddr, c, OFS_MODE) ? {22'h000000, mode_reg} :
                         hit(paddr, c, OFS_CTRL) ? {30'h00000000, srst_reg, en_reg} :
                         hit(paddr, c, OFS_TXD) ? {16'h0000, txd_reg} :
                         hit(paddr, c, OFS_RXD) ? {16'h0000, rxd_reg} :
                         hit(paddr, c, OFS_FLAG) ? {23'h000000, st_reg == SSMS_XFER, 4'h0,
                                                    ovr_reg, tend_reg, rbf_reg, !tx_full_reg} :
                         32'h0000_0000;

    always_comb begin
      mode_next = mode_reg;
      en_next = en_reg;
      srst_next = 1'b0;
      txd_next = txd_reg;
      rxd_next = rxd_reg;
      txw_next = txw_reg;
      rxw_next = rxw_reg;
      tx_full_next = tx_full_reg;
      rbf_next = rbf_reg;
      tend_next = tend_reg;
      ovr_next = ovr_reg;
      st_next = st_reg;
      cnt_next = cnt_reg;
      phase_next = phase_reg;
      sdo_next = sdo_reg;
      load = 1'b0;
      wr_tx = wr_done && hit(paddr, c, OFS_TXD);
      rd_rx = rd_done && hit(paddr, c, OFS_RXD);
      // Master edges come from the timer; slave edges from the pin
      raw = mode_reg.clock_bypass_select ? timer_clk[c] : tog_reg;
      tog_next = tog_reg ^ timer_underflow[c];
      raw_prev_next = raw;
      act = pin_in[c].shift_clock_pin ^ mode_reg.cpol;
      act_prev_next = act;
      sel = !pin_in[c].slave_select_n_pin;
      if (mode_reg.mst) begin
        lead = (st_reg == SSMS_XFER) && (raw != raw_prev_reg) && !phase_reg;
        trail = (st_reg == SSMS_XFER) && (raw != raw_prev_reg) && phase_reg;
      end else begin
        lead = (st_reg == SSMS_XFER) && sel && act && !act_prev_reg;
        trail = (st_reg == SSMS_XFER) && sel && !act && act_prev_reg;
      end
      if (lead || trail) begin
        phase_next = !phase_reg;
      end
      samp = mode_reg.cpha ? trail : lead;
      last = trail && (cnt_reg[3:0] == mode_reg.len_m1);
      rx_word = rxw_reg;
      if (samp) begin
        rx_word[bit_pos(mode_reg.lsb_first, mode_reg.len_m1, cnt_reg)] = pin_in[c].serial_data_in_pin;
      end
      rxw_next = rx_word;
      // Phase 1 launches on the leading edge, phase 0 on the trailing edge
      if (lead && mode_reg.cpha) begin
        sdo_next = txw_reg[bit_pos(mode_reg.lsb_first, mode_reg.len_m1, cnt_reg)];
      end
      if (trail) begin
        cnt_next = cnt_reg + 5'd1;
        if (!mode_reg.cpha && !last) begin
          sdo_next = txw_reg[bit_pos(mode_reg.lsb_first, mode_reg.len_m1, cnt_reg + 5'd1)];
        end
      end
      if (last) begin
        rxd_next = rx_word;
        rbf_next = 1'b1;
        if (rbf_reg && !rd_rx) begin
          ovr_next = 1'b1;
        end
        if (tx_full_reg || !mode_reg.mst) begin
          load = 1'b1;
        end else begin
          st_next = SSMS_IDLE;
          tend_next = 1'b1;
        end
      end
      if (st_reg == SSMS_IDLE && en_reg && (mode_reg.mst ? tx_full_reg : sel)) begin
        load = 1'b1;
        st_next = SSMS_XFER;
        phase_next = 1'b0;
      end
      if (load) begin
        cnt_next = 5'd0;
        rxw_next = DATA_RESET;
        if (tx_full_reg) begin
          txw_next = txd_reg;
          tx_full_next = 1'b0;
        end
        sdo_next = (tx_full_reg ? txd_reg[bit_pos(mode_reg.lsb_first, mode_reg.len_m1, 5'd0)] :
                    txw_reg[bit_pos(mode_reg.lsb_first, mode_reg.len_m1, 5'd0)]);
      end
      if (!mode_reg.mst && !sel) begin
        st_next = SSMS_IDLE;
        cnt_next = 5'd0;
        rxw_next = DATA_RESET;
      end
      if (!en_reg) begin
        st_next = SSMS_IDLE;
      end
      // Register writes; flag sets above take priority over clears, but a pending soft reset (srst_reg) clears the flags over any set
      if (wr_done && hit(paddr, c, OFS_MODE)) begin
        mode_next = pwdata[9:0];
        if (pwdata[3:0] == 4'h0) begin
          mode_next.len_m1 = LEN_M1_MIN;
        end
      end
      if (wr_done && hit(paddr, c, OFS_CTRL)) begin
        en_next = pwdata[CTRL_EN_BIT];
        srst_next = pwdata[CTRL_SRST_BIT];
      end
      if (wr_tx) begin
        txd_next = pwdata[15:0];
        tx_full_next = 1'b1;
      end
      if (rd_rx && !last) begin
        rbf_next = 1'b0;
      end
      if (wr_done && hit(paddr, c, OFS_FLAG)) begin
        if (pwdata[FLAG_TEND_BIT] && !tend_next) begin
          tend_next = 1'b0;
        end else if (pwdata[FLAG_TEND_BIT] && !(last && !tx_full_reg && mode_reg.mst)) begin
          tend_next = 1'b0;
        end
        if (pwdata[FLAG_OVR_BIT] && !(last && rbf_reg && !rd_rx)) begin
          ovr_next = 1'b0;
        end
      end
      if (srst_reg) begin
        st_next = SSMS_IDLE;
        tx_full_next = 1'b0;
        rbf_next = 1'b0;
        tend_next = 1'b0;
        ovr_next = 1'b0;
        cnt_next = 5'd0;
        rxw_next = DATA_RESET;
      end
      // Pins lag state by one cycle so that every output is a flop
      pin_next.serial_data_out_pin = sdo_reg;
      pin_next.serial_data_out_oe = en_reg && (mode_reg.mst || sel);
      pin_next.shift_clock_out = mode_reg.cpol ^ phase_reg;
      pin_next.shift_clock_oe = en_reg && mode_reg.mst;
      pin_next.pull_up_data_in = mode_reg.pull_enable;
      pin_next.pull_up_clock = mode_reg.pull_enable && !mode_reg.mst && mode_reg.cpol;
      pin_next.pull_down_clock = mode_reg.pull_enable && !mode_reg.mst && !mode_reg.cpol;
      pin_next.pull_up_select = mode_reg.pull_enable && !mode_reg.mst;
      cause_next.busy = st_reg == SSMS_XFER;
      cause_next.overrun = ovr_reg;
      cause_next.tx_end = tend_reg;
      cause_next.rx_full = rbf_reg;
      cause_next.tx_empty = !tx_full_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_reg <= MODE_RESET;
        en_reg <= 1'b0;
        srst_reg <= 1'b0;
        txd_reg <= DATA_RESET;
        rxd_reg <= DATA_RESET;
        txw_reg <= DATA_RESET;
        rxw_reg <= DATA_RESET;
        tx_full_reg <= 1'b0;
        rbf_reg <= 1'b0;
        tend_reg <= 1'b0;
        ovr_reg <= 1'b0;
        st_reg <= SSMS_IDLE;
        cnt_reg <= 5'd0;
        phase_reg <= 1'b0;
        tog_reg <= 1'b0;
        raw_prev_reg <= 1'b0;
        act_prev_reg <= 1'b0;
        sdo_reg <= 1'b0;
        pin_reg <= '0;
        cause_reg <= '0;
      end else if (clk_en) begin
        mode_reg <= mode_next;
        en_reg <= en_next;
        srst_reg <= srst_next;
        txd_reg <= txd_next;
        rxd_reg <= rxd_next;
        txw_reg <= txw_next;
        rxw_reg <= rxw_next;
        tx_full_reg <= tx_full_next;
        rbf_reg <= rbf_next;
        tend_reg <= tend_next;
        ovr_reg <= ovr_next;
        st_reg <= st_next;
        cnt_reg <= cnt_next;
        phase_reg <= phase_next;
        tog_reg <= tog_next;
        raw_prev_reg <= raw_prev_next;
        act_prev_reg <= act_prev_next;
        sdo_reg <= sdo_next;
        pin_reg <= pin_next;
        cause_reg <= cause_next;
      end
    end

    assign pin_out[c] = pin_reg;
    assign cause[c] = cause_reg;
  end

endmodule
`default_nettype wire

/* File: design/ssms_pkg.sv */
// Purpose: Shared constants and types of the synchronous serial block
// Assumes: 32-bit APB, two channels, byte addresses
// Notes: Each channel occupies a window of ADDR_CH_STRIDE bytes
`default_nettype none
package ssms_pkg;
  localparam int NUM_CH = 2;
  localparam int DATA_W = 16;
  localparam logic [11:0] ADDR_CH_STRIDE = 12'h020;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_TXD = 5'h08;
  localparam logic [4:0] OFS_RXD = 5'h0C;
  localparam logic [4:0] OFS_FLAG = 5'h10;
  // Mode word fields
  localparam int MODE_LEN_LSB = 0;
  localparam int MODE_CPHA_BIT = 4;
  localparam int MODE_CPOL_BIT = 5;
  localparam int MODE_LSBF_BIT = 6;
  localparam int MODE_BYP_BIT = 7;
  localparam int MODE_PULL_BIT = 8;
  localparam int MODE_MST_BIT = 9;
  // Control word fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  // Flag word fields
  localparam int FLAG_TBE_BIT = 0;
  localparam int FLAG_RBF_BIT = 1;
  localparam int FLAG_TEND_BIT = 2;
  localparam int FLAG_OVR_BIT = 3;
  localparam int FLAG_BUSY_BIT = 8;
  localparam logic [3:0] LEN_M1_MIN = 4'h1;
  localparam logic [9:0] MODE_RESET = 10'h000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef struct packed {
    logic mst;
    logic pull_enable;
    logic clock_bypass_select;
    logic lsb_first;
    logic cpol;
    logic cpha;
    logic [3:0] len_m1;
  } ssms_mode_type;

  typedef struct packed {
    logic serial_data_in_pin;
    logic shift_clock_pin;
    logic slave_select_n_pin;
  } ssms_pin_in_type;

  typedef struct packed {
    logic serial_data_out_pin;
    logic serial_data_out_oe;
    logic shift_clock_out;
    logic shift_clock_oe;
    logic pull_up_data_in;
    logic pull_up_clock;
    logic pull_down_clock;
    logic pull_up_select;
  } ssms_pin_out_type;

  typedef struct packed {
    logic busy;
    logic overrun;
    logic tx_end;
    logic rx_full;
    logic tx_empty;
  } ssms_flags_type;

  typedef enum logic {SSMS_IDLE, SSMS_XFER} ssms_state_type;
endpackage
`default_nettype wire

/* File: verif/ssms_sva.sv */
// Purpose: Port-level checks of the serial block
// Assumes: Channel 0 runs as master, channel 1 as slave
// Notes: The clock cause window allows a pin lag of one to three cycles
`default_nettype none
module ssms_chk
  import ssms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] timer_clk,
  input wire logic [NUM_CH-1:0] timer_underflow,
  input wire ssms_pin_in_type [NUM_CH-1:0] pin_in,
  input wire ssms_pin_out_type [NUM_CH-1:0] pin_out
);
  logic tclk_reg;
  logic [2:0] ev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_reg <= 1'b0;
      ev_reg <= 3'h0;
    end else if (clk_en) begin
      // Count only enabled edges, as the block does, so a freeze never hides a pending event
      tclk_reg <= timer_clk[0];
      ev_reg <= {ev_reg[1:0], timer_underflow[0] | (timer_clk[0] ^ tclk_reg)};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence slave_idle_s;
    (clk_en && !pin_out[1].shift_clock_oe && pin_in[1].slave_select_n_pin)[*2];
  endsequence
  setup_answer_a: assert property (apb_setup_s |=> pready)
    else $error("no answer after setup");
  unmapped_err_a: assert property (apb_setup_s and paddr[11:6] != 6'h00 |=> pready && pslverr)
    else $error("unmapped access not refused");
  master_drive_a: assert property (pin_out[0].shift_clock_oe |-> pin_out[0].serial_data_out_oe)
    else $error("master data output not driven");
  slave_float_a: assert property (slave_idle_s |=> !pin_out[1].serial_data_out_oe)
    else $error("deselected slave drives data");
  clock_pull_a: assert property ((pin_out[1].pull_up_clock || pin_out[1].pull_down_clock) |->
    !(pin_out[1].pull_up_clock && pin_out[1].pull_down_clock) && !pin_out[1].shift_clock_oe)
    else $error("clock pull wrong");
  master_nopull_a: assert property (pin_out[0].shift_clock_oe |->
    !pin_out[0].pull_up_select && !pin_out[0].pull_up_clock && !pin_out[0].pull_down_clock)
    else $error("master pulls clock or select");
  reset_hiz_a: assert property ($rose(presetn) |-> pin_out == '0)
    else $error("pins driven after reset");
  clock_cause_a: assert property ($changed(pin_out[0].shift_clock_out) && pin_out[0].shift_clock_oe
    && $past(pin_out[0].shift_clock_oe) |-> ev_reg != 3'h0)
    else $error("master clock moved without timer event");
endmodule
bind ssms_top ssms_chk chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .timer_clk(timer_clk), .timer_underflow(timer_underflow),
  .pin_in(pin_in), .pin_out(pin_out));
`default_nettype wire

/* File: verif/ssms_slave_model.sv */
// Purpose: Behavioural serial slave facing channel 0
// Assumes: Clock idles low, sample on rise, shift on fall, 8 bits MSB first
// Notes: Deselected output toggles each cycle so a stale bit never looks valid
`default_nettype none
module ssms_slave_model #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input wire logic pclk,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_reg = 1'b0;
  logic idle_reg = 1'b0;
  logic [7:0] tx_reg = 8'h00;
  always @(posedge pclk) begin
    sclk_reg <= sclk;
    idle_reg <= ~idle_reg;
    if (select_n) begin
      tx_reg <= REPLY;
    end else if (sclk && !sclk_reg) begin
      got <= {got[6:0], mosi};
    end else if (!sclk && sclk_reg) begin
      tx_reg <= {tx_reg[6:0], tx_reg[7]};
    end
  end
  assign miso = select_n ? idle_reg : tx_reg[7];
endmodule
`default_nettype wire

/* File: verif/tb_sync_serial_master_slave.sv */
// Purpose: Self-checking bench, channel 0 master, channel 1 slave
// Assumes: APB answers within 50 access cycles
// Notes: Only clock mode 0 and mode 2 are exercised for lack of room
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_sync_serial_master_slave
  import ssms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] timer_clk = 2'h0;
  logic [1:0] timer_underflow = 2'h0;
  logic [1:0] tcnt = 2'h0;
  ssms_pin_in_type [NUM_CH-1:0] pin_in;
  ssms_pin_in_type s1_in = '{1'b0, 1'b1, 1'b1};
  ssms_pin_out_type [NUM_CH-1:0] pin_out;
  ssms_flags_type [NUM_CH-1:0] cause;
  logic mdl_sel_n = 1'b1;
  logic miso;
  logic [7:0] got;
  int errors = 0;
  int cmp_count = 0;
  ssms_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_clk(timer_clk),
    .timer_underflow(timer_underflow), .pin_in(pin_in), .pin_out(pin_out), .cause(cause));
  ssms_slave_model mdl (.pclk(pclk), .select_n(mdl_sel_n), .sclk(pin_out[0].shift_clock_out),
    .mosi(pin_out[0].serial_data_out_pin), .miso(miso), .got(got));
  assign pin_in = {s1_in, {miso, pin_out[0].shift_clock_out, 1'b1}};
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Timer stand-in: underflow every four cycles, its clock toggling with it
  always @(posedge pclk) begin
    tcnt <= tcnt + 2'h1;
    timer_underflow <= (tcnt == 2'h0) ? 2'h3 : 2'h0;
    if (tcnt == 2'h0) begin
      timer_clk <= ~timer_clk;
    end
  end
  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  function automatic logic [11:0] ad(input logic c, input logic [4:0] o);
    return (c ? ADDR_CH_STRIDE : 12'h000) | {7'h00, o};
  endfunction
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask
  task automatic wait_flag(input int c, input int b);
    int n;
    logic [4:0] f;
    n = 0;
    f = 5'h00;
    while (f[b] !== 1'b1) begin
      @(posedge pclk);
      f = cause[c];
      n++;
      if (n > 500) begin
        errors++;
        complete_run();
      end
    end
  endtask
  task automatic sbit(input logic d, output logic so);
    s1_in.serial_data_in_pin <= d;
    repeat (3) @(posedge pclk);
    so = pin_out[1].serial_data_out_pin;
    s1_in.shift_clock_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    s1_in.shift_clock_pin <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    `CHK(pin_out, '0)
    rdc(ad(1'b0, OFS_MODE), 32'h0);
    rdc(ad(1'b0, OFS_FLAG), 32'h1);
    apb(1'b0, 12'h040, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, 12'h014, 32'hF, q, e);
    `CHK(e, 1'b1)
  endtask
  task automatic t_master();
    ssms_pin_out_type p;
    mdl_sel_n <= 1'b0;
    wr(ad(1'b0, OFS_MODE), 32'h207);
    rdc(ad(1'b0, OFS_MODE), 32'h207);
    wr(ad(1'b0, OFS_CTRL), 32'h1);
    repeat (3) @(posedge pclk);
    `CHK({pin_out[0].shift_clock_oe, pin_out[0].serial_data_out_oe}, 2'h3)
    wr(ad(1'b0, OFS_TXD), 32'h96);
    // Freeze mid-frame: pins must hold, and the frame must still complete afterwards
    repeat (20) @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    p = pin_out[0];
    repeat (8) @(posedge pclk);
    `CHK(pin_out[0], p)
    clk_en <= 1'b1;
    wait_flag(0, 2);
    `CHK(got, 8'h96)
    rdc(ad(1'b0, OFS_FLAG), 32'h7);
    wr(ad(1'b0, OFS_FLAG), 32'h4);
    rdc(ad(1'b0, OFS_FLAG), 32'h3);
    wr(ad(1'b0, OFS_TXD), 32'h4B);
    wait_flag(0, 2);
    `CHK(got, 8'h4B)
    rdc(ad(1'b0, OFS_FLAG), 32'hF);
    rdc(ad(1'b0, OFS_RXD), 32'h3C);
    rdc(ad(1'b0, OFS_FLAG), 32'hD);
    wr(ad(1'b0, OFS_FLAG), 32'hC);
    rdc(ad(1'b0, OFS_FLAG), 32'h1);
    // Bypass: timer clock level changes drive the shift clock directly
    wr(ad(1'b0, OFS_MODE), 32'h287);
    wr(ad(1'b0, OFS_TXD), 32'hA5);
    rdc(ad(1'b0, OFS_FLAG), 32'h101);
    wait_flag(0, 2);
    `CHK(got, 8'hA5)
    rdc(ad(1'b0, OFS_RXD), 32'h3C);
    mdl_sel_n <= 1'b1;
  endtask
  task automatic t_slave();
    logic [3:0] sv;
    logic so;
    wr(ad(1'b1, OFS_MODE), 32'h0);
    rdc(ad(1'b1, OFS_MODE), 32'h1);
    wr(ad(1'b1, OFS_MODE), 32'h143);
    repeat (3) @(posedge pclk);
    `CHK({pin_out[1].pull_up_clock, pin_out[1].pull_down_clock}, 2'h1)
    wr(ad(1'b1, OFS_MODE), 32'h163);
    repeat (3) @(posedge pclk);
    `CHK(pin_out[1][4:0], 5'h0D)
    `CHK(pin_out[1].serial_data_out_oe, 1'b0)
    wr(ad(1'b1, OFS_CTRL), 32'h1);
    wr(ad(1'b1, OFS_TXD), 32'hA);
    s1_in.slave_select_n_pin <= 1'b0;
    sbit(1'b1, so);
    sbit(1'b1, so);
    s1_in.slave_select_n_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(pin_out[1].serial_data_out_oe, 1'b0)
    wr(ad(1'b1, OFS_TXD), 32'h5);
    s1_in.slave_select_n_pin <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      sbit(((4'h6 >> i) & 4'h1) != 4'h0, so);
      sv[i] = so;
    end
    s1_in.slave_select_n_pin <= 1'b1;
    wait_flag(1, 1);
    `CHK(sv, 4'h5)
    rdc(ad(1'b1, OFS_RXD), 32'h6);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_master();
    t_slave();
    complete_run();
  end
endmodule
`default_nettype wire
